// ===== verilog/system_control_register_bank.sv
// Miscellaneous system control register bank on the processor special function bus.
`timescale 1ns/1ps
`default_nettype none
module system_control_register_bank #(
  parameter logic [1:0] FLASH_SIZE_CODE = 2'h3,  // Flash capacity code of this build.
  parameter logic [5:0] PART_LOW_UPPER  = 6'h00, // Arbitrary value, upper low-code bits.
  parameter logic [7:0] PART_HIGH_CODE  = 8'h5A  // Arbitrary value, high product code.
) (
  input  wire logic       mclk,               // System clock, 100 MHz.
  input  wire logic       rstn,               // Asynchronous reset, active low.
  input  wire logic [7:0] sfr_addr,           // Register address.
  input  wire logic [7:0] sfr_wdata,          // Write data.
  input  wire logic       sfr_wr,             // Write strobe, one cycle.
  input  wire logic       sfr_rd,             // Read strobe, one cycle.
  output logic      [7:0] sfr_rdata,          // Registered read data.
  input  wire logic [15:0] millisecond_divider, // Millisecond divider value.
  input  wire logic [4:0] microsecond_divider, // Microsecond divider value.
  input  wire logic [7:0] hundred_ms_divider, // Hundred-ms divider value.
  input  wire logic       flash_erase_start,  // Pulse starting a flash erase.
  input  wire logic       flash_write_start,  // Pulse starting a flash write.
  output logic            flash_busy,         // Flash write or erase in progress.
  output logic            page_wipe_enable,   // Page erase mode.
  output logic            delay_line_select,  // Flash timing from delay line.
  output logic      [4:0] power_off,          // Per-peripheral power-down bits.
  output logic            analog_power_off,   // Reference, summation, brownout off.
  output logic            strobe_pin_oe,      // Strobe pin overridden by this block.
  output logic            strobe_pin_out,     // Strobe pin level when overridden.
  output logic            latch_pin_oe,       // Address latch pin overridden.
  output logic            latch_pin_out,      // Address latch pin level when overridden.
  output logic            converter_clk_en,   // Converter clock enable pulse.
  output logic            modulator_clk_en,   // Modulator clock enable pulse.
  output logic            soft_reboot,        // System reset request pulse.
  output logic      [4:0] ext_int_priority,   // Watchdog and external 5-2 priorities.
  output logic            slow_tick_irq,      // Pending slow tick interrupt.
  output logic      [7:0] second_accumulator  // Second accumulator value.
);

  // Address decoding used by both the write and read paths.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic        wr_ft, wr_acc, wr_pd, wr_ps, wr_cd, wr_sr, wr_pr, wr_st, rd_st;
  logic [7:0]  flash_timing_reg, flash_timing_next;
  logic [7:0]  acc_reg, acc_next;
  logic [4:0]  pd_reg, pd_next;
  logic [5:0]  ps_reg, ps_next;
  logic [4:0]  cd_reg, cd_next;
  logic        sr_reg, sr_next;
  logic [4:0]  pr_reg, pr_next;
  logic        pw_reg, pw_next;
  logic        dl_reg, dl_next;

  assign wr_ft  = sfr_wr && hit(sfr_addr, sysctl_pkg::OFF_FLASH_TIMING);
  assign wr_acc = sfr_wr && hit(sfr_addr, sysctl_pkg::OFF_SECOND_ACC);
  assign wr_pd  = sfr_wr && hit(sfr_addr, sysctl_pkg::OFF_POWER_DOWN);
  assign wr_ps  = sfr_wr && hit(sfr_addr, sysctl_pkg::OFF_STROBE_SEL);
  assign wr_cd  = sfr_wr && hit(sfr_addr, sysctl_pkg::OFF_CONV_CLK_DIV);
  assign wr_sr  = sfr_wr && hit(sfr_addr, sysctl_pkg::OFF_SOFT_REBOOT);
  assign wr_pr  = sfr_wr && hit(sfr_addr, sysctl_pkg::OFF_EXT_INT_PRIO);
  assign wr_st  = sfr_wr && hit(sfr_addr, sysctl_pkg::OFF_SLOW_TICK);
  assign rd_st  = sfr_rd && hit(sfr_addr, sysctl_pkg::OFF_SLOW_TICK);

  // Next values of the plain control registers; fixed bits are not stored, save strobe select bit 2, which is held at zero.
  always_comb begin
    flash_timing_next = wr_ft ? sfr_wdata : flash_timing_reg;
    acc_next = wr_acc ? sfr_wdata : acc_reg;
    pd_next  = wr_pd ? sfr_wdata[4:0] : pd_reg;
    ps_next  = wr_ps ? {sfr_wdata[5:3], 1'b0, sfr_wdata[1:0]} : ps_reg;
    cd_next  = wr_cd ? sfr_wdata[4:0] : cd_reg;
    sr_next  = wr_sr ? sfr_wdata[0] : sr_reg;
    pr_next  = wr_pr ? sfr_wdata[4:0] : pr_reg;
    pw_next  = pw_reg;
    dl_next  = dl_reg;
    if (sfr_wr && hit(sfr_addr, sysctl_pkg::OFF_FLASH_CONTROL)) begin
      pw_next = sfr_wdata[sysctl_pkg::BIT_PAGE_WIPE];
      dl_next = sfr_wdata[sysctl_pkg::BIT_DELAY_LINE];
    end
  end

  // Registers the control state.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flash_timing_reg <= sysctl_pkg::RST_FLASH_TIMING;
      acc_reg <= sysctl_pkg::RST_SECOND_ACC;
      pd_reg  <= sysctl_pkg::RST_POWER_DOWN[4:0];
      ps_reg  <= sysctl_pkg::RST_STROBE_SEL[5:0];
      cd_reg  <= sysctl_pkg::RST_CONV_CLK_DIV;
      sr_reg  <= 1'b0;
      pr_reg  <= 5'h00;
      pw_reg  <= 1'b0;
      dl_reg  <= 1'b0;
    end else begin
      flash_timing_reg <= flash_timing_next;
      acc_reg <= acc_next;
      pd_reg  <= pd_next;
      ps_reg  <= ps_next;
      cd_reg  <= cd_next;
      sr_reg  <= sr_next;
      pr_reg  <= pr_next;
      pw_reg  <= pw_next;
      dl_reg  <= dl_next;
    end
  end

  // Tick dividers: microsecond, millisecond, hundred-ms, converter and modulator.
  logic [4:0]  us_cnt_reg, us_cnt_next;
  logic [15:0] ms_cnt_reg, ms_cnt_next;
  logic [7:0]  hm_cnt_reg, hm_cnt_next;
  logic [4:0]  cv_cnt_reg, cv_cnt_next;
  logic [5:0]  md_cnt_reg, md_cnt_next;
  logic        us_tick, ms_tick, hm_tick, cv_tick;

  assign us_tick = (us_cnt_reg == microsecond_divider);
  assign ms_tick = (ms_cnt_reg == millisecond_divider);
  assign hm_tick = ms_tick && (hm_cnt_reg == hundred_ms_divider);
  assign cv_tick = (cv_cnt_reg == cd_reg);

  always_comb begin
    us_cnt_next = us_tick ? 5'h00 : us_cnt_reg + 5'h01;
    ms_cnt_next = ms_tick ? 16'h0000 : ms_cnt_reg + 16'h0001;
    hm_cnt_next = hm_cnt_reg;
    if (ms_tick) begin
      hm_cnt_next = hm_tick ? 8'h00 : hm_cnt_reg + 8'h01;
    end
    cv_cnt_next = cv_tick ? 5'h00 : cv_cnt_reg + 5'h01;
    md_cnt_next = md_cnt_reg;
    if (cv_tick) begin
      md_cnt_next = md_cnt_reg + 6'h01;
    end
    // The microsecond, millisecond and converter dividers restart rather than wrap when shrunk below their count.
    if (us_cnt_reg > microsecond_divider) begin
      us_cnt_next = 5'h00;
    end
    if (ms_cnt_reg > millisecond_divider) begin
      ms_cnt_next = 16'h0000;
    end
    if (cv_cnt_reg > cd_reg) begin
      cv_cnt_next = 5'h00;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      us_cnt_reg <= 5'h00;
      ms_cnt_reg <= 16'h0000;
      hm_cnt_reg <= 8'h00;
      cv_cnt_reg <= 5'h00;
      md_cnt_reg <= 6'h00;
    end else begin
      us_cnt_reg <= us_cnt_next;
      ms_cnt_reg <= ms_cnt_next;
      hm_cnt_reg <= hm_cnt_next;
      cv_cnt_reg <= cv_cnt_next;
      md_cnt_reg <= md_cnt_next;
    end
  end

  // Flash timer: erase counts millisecond ticks, write counts 5 * (field + 1) microsecond ticks.
  sysctl_pkg::flash_state_t fl_state_reg, fl_state_next;
  logic [6:0] fl_cnt_reg, fl_cnt_next;
  logic       fl_tick;

  assign fl_tick = (fl_state_reg == sysctl_pkg::FL_ERASE) ? ms_tick : us_tick;

  always_comb begin
    fl_state_next = fl_state_reg;
    fl_cnt_next   = fl_cnt_reg;
    case (fl_state_reg)
      sysctl_pkg::FL_IDLE: begin
        if (flash_erase_start) begin
          fl_state_next = sysctl_pkg::FL_ERASE;
          fl_cnt_next   = {3'h0, flash_timing_reg[7:4]};
        end else if (flash_write_start) begin
          fl_state_next = sysctl_pkg::FL_WRITE;
          fl_cnt_next   = 7'((32'(flash_timing_reg[3:0]) + 32'd1)
                            * sysctl_pkg::WRITE_MULT - 1);
        end
      end
      sysctl_pkg::FL_ERASE, sysctl_pkg::FL_WRITE: begin
        if (fl_tick) begin
          if (fl_cnt_reg == 7'h00) begin
            fl_state_next = sysctl_pkg::FL_IDLE;
          end else begin
            fl_cnt_next = fl_cnt_reg - 7'h01;
          end
        end
      end
      default: fl_state_next = sysctl_pkg::FL_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fl_state_reg <= sysctl_pkg::FL_IDLE;
      fl_cnt_reg   <= 7'h00;
    end else begin
      fl_state_reg <= fl_state_next;
      fl_cnt_reg   <= fl_cnt_next;
    end
  end

  // Slow tick timer with deferred or immediate reload and clear-on-read interrupt.
  logic [6:0] st_reload_reg, st_reload_next;
  logic [6:0] st_cnt_reg, st_cnt_next;
  logic       st_irq_reg, st_irq_next;
  logic       st_expire;

  assign st_expire = hm_tick && (st_cnt_reg == 7'h00);

  always_comb begin
    st_reload_next = wr_st ? sfr_wdata[6:0] : st_reload_reg;
    st_cnt_next    = st_cnt_reg;
    if (wr_st && sfr_wdata[sysctl_pkg::BIT_LOAD_IMM]) begin
      st_cnt_next = sfr_wdata[6:0];
    end else if (hm_tick) begin
      st_cnt_next = st_expire ? st_reload_next : st_cnt_reg - 7'h01;
    end
    // A new expiry wins over a clearing read in the same cycle.
    st_irq_next = st_expire ? 1'b1 : (rd_st ? 1'b0 : st_irq_reg);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_reload_reg <= sysctl_pkg::RST_SLOW_TICK;
      st_cnt_reg    <= sysctl_pkg::RST_SLOW_TICK;
      st_irq_reg    <= 1'b0;
    end else begin
      st_reload_reg <= st_reload_next;
      st_cnt_reg    <= st_cnt_next;
      st_irq_reg    <= st_irq_next;
    end
  end

  // Read multiplexer; fixed bits come from constants, unmapped addresses read zero.
  logic [7:0] rdata_next;
  always_comb begin
    case (sfr_addr)
      sysctl_pkg::OFF_PART_ID_LOW:   rdata_next = {PART_LOW_UPPER, FLASH_SIZE_CODE};
      sysctl_pkg::OFF_PART_ID_HIGH:  rdata_next = PART_HIGH_CODE;
      sysctl_pkg::OFF_FLASH_CONTROL: rdata_next = sysctl_pkg::FLASH_CTL_FIXED
                                       | {1'b0, pw_reg, 1'b0, dl_reg, 1'b0,
                                          (fl_state_reg != sysctl_pkg::FL_IDLE),
                                          2'b00};
      sysctl_pkg::OFF_FLASH_TIMING:  rdata_next = flash_timing_reg;
      sysctl_pkg::OFF_SECOND_ACC:    rdata_next = acc_reg;
      sysctl_pkg::OFF_POWER_DOWN:    rdata_next = {3'h0, pd_reg};
      sysctl_pkg::OFF_STROBE_SEL:    rdata_next = {2'h0, ps_reg};
      sysctl_pkg::OFF_CONV_CLK_DIV:  rdata_next = {3'h0, cd_reg};
      sysctl_pkg::OFF_SOFT_REBOOT:   rdata_next = {7'h00, sr_reg};
      sysctl_pkg::OFF_EXT_INT_PRIO:  rdata_next = sysctl_pkg::PRIO_FIXED | {3'h0, pr_reg};
      sysctl_pkg::OFF_SLOW_TICK:     rdata_next = {1'b0, st_reload_reg};
      default:                       rdata_next = 8'h00;
    endcase
  end

  // Output flops: pin functions, enables, reboot pulse and read data.
  logic [1:0] stb_mode;
  logic       stb_oe_next, stb_out_next, lat_oe_next, lat_out_next, reboot_next;
  assign stb_mode = ps_reg[5:4];

  always_comb begin
    stb_oe_next  = (stb_mode != sysctl_pkg::STB_NORMAL);
    case (stb_mode)
      sysctl_pkg::STB_SYSCLK: stb_out_next = us_cnt_reg[0];
      sysctl_pkg::STB_MODULATOR_CLOCK: stb_out_next = md_cnt_reg[5];
      sysctl_pkg::STB_FORCED: stb_out_next = ps_reg[3];
      default:                stb_out_next = 1'b0;
    endcase
    lat_oe_next  = ps_reg[1];
    lat_out_next = ps_reg[0];
    reboot_next  = sr_reg && wr_sr && !sfr_wdata[0];
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata          <= 8'h00;
      flash_busy         <= 1'b0;
      page_wipe_enable   <= 1'b0;
      delay_line_select  <= 1'b0;
      power_off          <= sysctl_pkg::RST_POWER_DOWN[4:0];
      analog_power_off   <= 1'b1;
      strobe_pin_oe      <= 1'b0;
      strobe_pin_out     <= 1'b0;
      latch_pin_oe       <= 1'b0;
      latch_pin_out      <= 1'b0;
      converter_clk_en   <= 1'b0;
      modulator_clk_en   <= 1'b0;
      soft_reboot        <= 1'b0;
      ext_int_priority   <= 5'h00;
      slow_tick_irq      <= 1'b0;
      second_accumulator <= 8'h00;
    end else begin
      sfr_rdata          <= rdata_next;
      flash_busy         <= (fl_state_next != sysctl_pkg::FL_IDLE);
      page_wipe_enable   <= pw_reg;
      delay_line_select  <= dl_reg;
      power_off          <= pd_reg;
      analog_power_off   <= pd_reg[sysctl_pkg::BIT_CONV_OFF];
      strobe_pin_oe      <= stb_oe_next;
      strobe_pin_out     <= stb_out_next;
      latch_pin_oe       <= lat_oe_next;
      latch_pin_out      <= lat_out_next;
      converter_clk_en   <= cv_tick;
      modulator_clk_en   <= cv_tick && (md_cnt_reg == sysctl_pkg::MOD_DIV_LAST);
      soft_reboot        <= reboot_next;
      ext_int_priority   <= pr_reg;
      slow_tick_irq      <= st_irq_next;
      second_accumulator <= acc_reg;
    end
  end

  // Checks on the block's own behaviour.
  property p_reboot_seq;
    @(posedge mclk) disable iff (!rstn)
      (wr_sr && sfr_wdata[0]) ##1 (wr_sr && !sfr_wdata[0]) |=> soft_reboot;
  endproperty
  a_reboot_seq: assert property (p_reboot_seq) else $error("reboot not issued");

  property p_busy_follows_start;
    @(posedge mclk) disable iff (!rstn)
      (fl_state_reg == sysctl_pkg::FL_IDLE && flash_erase_start) |=> flash_busy;
  endproperty
  a_busy_follows_start: assert property (p_busy_follows_start) else $error("busy not set");

  property p_irq_on_expire;
    @(posedge mclk) disable iff (!rstn) st_expire |=> slow_tick_irq;
  endproperty
  a_irq_on_expire: assert property (p_irq_on_expire) else $error("slow tick irq missed");

  property p_read_clears;
    @(posedge mclk) disable iff (!rstn) (rd_st && !st_expire) |=> !slow_tick_irq;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("irq not cleared");

  property p_prio_fixed;
    @(posedge mclk) disable iff (!rstn)
      (sfr_rd && sfr_addr == sysctl_pkg::OFF_EXT_INT_PRIO) |=> (sfr_rdata[7:5] == 3'h7);
  endproperty
  a_prio_fixed: assert property (p_prio_fixed) else $error("priority top bits wrong");

  property p_immediate_load;
    @(posedge mclk) disable iff (!rstn)
      (wr_st && sfr_wdata[7]) |=> (st_cnt_reg == $past(sfr_wdata[6:0]));
  endproperty
  a_immediate_load: assert property (p_immediate_load) else $error("immediate load failed");

  property p_analog_off;
    @(posedge mclk) disable iff (!rstn)
      wr_pd |=> ##1 (analog_power_off == $past(sfr_wdata[sysctl_pkg::BIT_CONV_OFF], 2));
  endproperty
  a_analog_off: assert property (p_analog_off) else $error("analog off mismatch");

  property p_size_code;
    @(posedge mclk) disable iff (!rstn)
      (sfr_rd && sfr_addr == sysctl_pkg::OFF_PART_ID_LOW) |=> (sfr_rdata[1:0] == FLASH_SIZE_CODE);
  endproperty
  a_size_code: assert property (p_size_code) else $error("size code wrong");

endmodule
`default_nettype wire

// ===== verilog/sysctl_pkg.sv
// Package with offsets, field positions, reset values and timing constants of the control bank.
package sysctl_pkg;
  localparam logic [7:0] OFF_PART_ID_LOW   = 8'hE9;
  localparam logic [7:0] OFF_PART_ID_HIGH  = 8'hEA;
  localparam logic [7:0] OFF_FLASH_CONTROL = 8'hEE;
  localparam logic [7:0] OFF_FLASH_TIMING  = 8'hEF;
  localparam logic [7:0] OFF_SECOND_ACC    = 8'hF0;
  localparam logic [7:0] OFF_POWER_DOWN    = 8'hF1;
  localparam logic [7:0] OFF_STROBE_SEL    = 8'hF2;
  localparam logic [7:0] OFF_CONV_CLK_DIV  = 8'hF6;
  localparam logic [7:0] OFF_SOFT_REBOOT   = 8'hF7;
  localparam logic [7:0] OFF_EXT_INT_PRIO  = 8'hF8;
  localparam logic [7:0] OFF_SLOW_TICK     = 8'hF9;

  localparam logic [7:0] RST_FLASH_TIMING  = 8'hA5;
  localparam logic [7:0] RST_SECOND_ACC    = 8'h00;
  localparam logic [7:0] RST_POWER_DOWN    = 8'h1F;
  localparam logic [7:0] RST_STROBE_SEL    = 8'h00;
  localparam logic [4:0] RST_CONV_CLK_DIV  = 5'h03;
  localparam logic [6:0] RST_SLOW_TICK     = 7'h7F;

  // Fixed bits of the flash control and priority registers.
  localparam logic [7:0] FLASH_CTL_FIXED   = 8'h02;
  localparam logic [7:0] PRIO_FIXED        = 8'hE0;

  localparam int BIT_PAGE_WIPE   = 6;
  localparam int BIT_DELAY_LINE  = 4;
  localparam int BIT_BUSY        = 2;
  localparam int BIT_CONV_OFF    = 3;
  localparam int BIT_LOAD_IMM    = 7;

  // Write duration multiplier and modulator divide ratio.
  localparam int WRITE_MULT      = 5;
  localparam logic [5:0] MOD_DIV_LAST = 6'h3F;

  // Strobe pin function codes.
  localparam logic [1:0] STB_NORMAL = 2'h0;
  localparam logic [1:0] STB_SYSCLK = 2'h1;
  localparam logic [1:0] STB_MODULATOR_CLOCK = 2'h2;
  localparam logic [1:0] STB_FORCED = 2'h3;

  typedef enum logic [1:0] {
    FL_IDLE  = 2'b00,
    FL_ERASE = 2'b01,
    FL_WRITE = 2'b10
  } flash_state_t;
endpackage

// ===== verification/testbench.sv
// Self-checking testbench for the system control register bank.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int LIMIT = 50000;
  logic        mclk, rstn, sfr_wr, sfr_rd, flash_erase_start, flash_write_start;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, hundred_ms_divider, second_accumulator;
  logic [15:0] millisecond_divider;
  logic [4:0]  microsecond_divider, power_off, ext_int_priority;
  logic        flash_busy, page_wipe_enable, delay_line_select, analog_power_off;
  logic        strobe_pin_oe, strobe_pin_out, latch_pin_oe, latch_pin_out;
  logic        converter_clk_en, modulator_clk_en, soft_reboot, slow_tick_irq;
  int          num_errors = 0, n_tests = 0, cyc = 0, reboots = 0, n, e, w, u;
  logic [31:0] seed;
  logic [7:0]  d;
  logic [7:0]  mdl[11];
  bit   [7:0]  offs[11] = '{8'hE9, 8'hEA, 8'hEE, 8'hEF, 8'hF0, 8'hF1, 8'hF2, 8'hF6, 8'hF8,
                           8'hF7, 8'hF9};
  bit   [7:0]  rstv[11] = '{8'h02, 8'h5A, 8'h02, 8'hA5, 8'h00, 8'h1F, 8'h00, 8'h03, 8'hE0,
                           8'h00, 8'h7F};
  bit   [7:0]  wmsk[11] = '{8'h00, 8'h00, 8'h50, 8'hFF, 8'hFF, 8'h1F, 8'h3B, 8'h1F, 8'h1F,
                           8'h00, 8'h00};

  // Flash size code 2 and an arbitrary high product code.
  system_control_register_bank #(.FLASH_SIZE_CODE(2'h2), .PART_LOW_UPPER(6'h00),
    .PART_HIGH_CODE(8'h5A)) dut (
    .mclk(mclk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .millisecond_divider(millisecond_divider), .microsecond_divider(microsecond_divider),
    .hundred_ms_divider(hundred_ms_divider), .flash_erase_start(flash_erase_start),
    .flash_write_start(flash_write_start), .flash_busy(flash_busy),
    .page_wipe_enable(page_wipe_enable), .delay_line_select(delay_line_select),
    .power_off(power_off), .analog_power_off(analog_power_off),
    .strobe_pin_oe(strobe_pin_oe), .strobe_pin_out(strobe_pin_out),
    .latch_pin_oe(latch_pin_oe), .latch_pin_out(latch_pin_out),
    .converter_clk_en(converter_clk_en), .modulator_clk_en(modulator_clk_en),
    .soft_reboot(soft_reboot), .ext_int_priority(ext_int_priority),
    .slow_tick_irq(slow_tick_irq), .second_accumulator(second_accumulator));

  // Clock of 10 ns period.
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // Cycle ceiling and reboot pulse counter.
  always @(posedge mclk) begin
    cyc++;
    if (soft_reboot === 1'b1) reboots++;
    if (cyc == LIMIT) begin
      num_errors++;
      complete_run();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic step(input int k);
    repeat (k) begin
      @(posedge mclk);
      #1;
    end
  endtask

  // Register accesses; a spare cycle keeps strobes from being re-raised at once.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    step(1);
    sfr_wr = 1'b0;
    step(1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    sfr_addr = a;
    sfr_rd = 1'b1;
    step(1);
    v = sfr_rdata;
    sfr_rd = 1'b0;
    step(1);
  endtask

  // Interval between two enable pulses of the chosen clock.
  task automatic gap(input bit m, output int k);
    k = 0;
    while ((m ? modulator_clk_en : converter_clk_en) !== 1'b1 && k < 3000) begin
      step(1);
      k++;
    end
    k = 0;
    do begin
      step(1);
      k++;
    end while ((m ? modulator_clk_en : converter_clk_en) !== 1'b1 && k < 3000);
  endtask

  // Counts cycles until the slow tick interrupt is seen, from a given start.
  task automatic wait_irq(inout int k);
    while (slow_tick_irq !== 1'b1 && k < 2000) begin
      step(1);
      k++;
    end
  endtask

  // Starts a flash operation and checks its busy length lies in the window.
  task automatic flash(input bit er, input int lo, input int hi);
    logic [7:0] v;
    int         k;
    flash_erase_start = er;
    flash_write_start = !er;
    step(1);
    flash_erase_start = 1'b0;
    flash_write_start = 1'b0;
    k = 1;
    rd(8'hEE, v);
    chk("busy_bit", 1, v[2]);
    k = 3;
    while (flash_busy === 1'b1 && k < 5000) begin
      step(1);
      if (flash_busy === 1'b1) k++;
    end
    chk("flash_len", 1, k >= lo && k <= hi);
    rd(8'hEE, v);
    chk("idle_bit", 0, v[2]);
  endtask

  initial begin
    seed = 32'd61946;
    {sfr_addr, sfr_wdata, sfr_wr, sfr_rd, flash_erase_start, flash_write_start} = '0;
    millisecond_divider = 16'h0003;
    hundred_ms_divider = 8'h01;
    microsecond_divider = 5'h00;
    rstn = 1'b0;
    repeat (10) @(posedge mclk);
    #1;
    rstn = 1'b1;
    chk("power_off", 8'h1F, power_off);
    chk("analog_off", 1, analog_power_off);
    for (int i = 0; i < 11; i++) begin
      rd(offs[i], d);
      chk("reset_read", rstv[i], d);
      mdl[i] = rstv[i];
    end
    rd(8'hF3, d);
    chk("unmapped", 8'h00, d);
    // Random writes against the mask model, identity registers included.
    for (int j = 0; j < 40; j++) begin
      n = int'(rnd() % 9);
      d = 8'(rnd());
      wr(offs[n], d);
      mdl[n] = (mdl[n] & ~wmsk[n]) | (d & wmsk[n]);
      rd(offs[n], d);
      chk("rw_read", mdl[n], d);
    end
    chk("acc_port", mdl[4], second_accumulator);
    chk("prio_port", mdl[8][4:0], ext_int_priority);
    chk("pd_port", mdl[5][4:0], power_off);
    chk("analog_port", mdl[5][3], analog_power_off);
    chk("wipe_port", mdl[2][6], page_wipe_enable);
    chk("dline_port", mdl[2][4], delay_line_select);
    // Flash erase and write durations with random fields.
    u = int'(rnd() % 4);
    microsecond_divider = 5'(u);
    e = 1 + int'(rnd() % 3);
    w = int'(rnd() % 4);
    wr(8'hEF, {4'(e), 4'(w)});
    flash(1'b1, e * 4 + 1, (e + 1) * 4 + 1);
    flash(1'b0, (5 * (w + 1) - 1) * (u + 1) + 1, 5 * (w + 1) * (u + 1) + 1);
    // Every strobe code, latch codes alongside.
    for (int k = 0; k < 8; k++) begin
      wr(8'hF2, {2'h0, 3'(k), 1'b0, 2'(k)});
      step(1);
      chk("strobe_oe", k >= 2, strobe_pin_oe);
      if (k >= 6) chk("strobe_out", k[0], strobe_pin_out);
      chk("latch_oe", k[1], latch_pin_oe);
      if (k[1]) chk("latch_out", k[0], latch_pin_out);
    end
    // Converter and modulator clock rates.
    e = int'(rnd() % 6);
    wr(8'hF6, 8'(e));
    gap(1'b0, n);
    chk("conv_gap", e + 1, n);
    gap(1'b1, n);
    chk("mod_gap", 64 * (e + 1), n);
    // Reboot only after set then clear.
    wr(8'hF7, 8'h01);
    step(2);
    chk("no_reboot", 0, reboots);
    wr(8'hF7, 8'h00);
    step(3);
    chk("reboot", 1, reboots);
    // Set and clear in two back-to-back writes also reboots.
    sfr_addr = 8'hF7;
    sfr_wdata = 8'h01;
    sfr_wr = 1'b1;
    step(1);
    sfr_wdata = 8'h00;
    step(1);
    sfr_wr = 1'b0;
    step(3);
    chk("reboot_back", 2, reboots);
    // Slow tick period after an immediate load, cleared by a read.
    e = int'(rnd() % 4);
    wr(8'hF9, 8'h80 | 8'(e));
    n = 0;
    while (slow_tick_irq !== 1'b1 && n < 2000) begin
      step(1);
      n++;
    end
    rd(8'hF9, d);
    chk("tick_wrt", 0, d[7]);
    step(1);
    chk("tick_clear", 0, slow_tick_irq);
    n = 3;
    while (slow_tick_irq !== 1'b1 && n < 2000) begin
      step(1);
      n++;
    end
    chk("tick_period", (e + 1) * 8, n);
    // Deferred reload: the running count ends first, then the new count applies.
    rd(8'hF9, d);
    w = int'(rnd() % 4);
    wr(8'hF9, 8'(w));
    n = 4;
    wait_irq(n);
    chk("tick_defer", (e + 1) * 8, n);
    rd(8'hF9, d);
    n = 2;
    wait_irq(n);
    chk("tick_new", (w + 1) * 8, n);
    complete_run();
  end
endmodule
`default_nettype wire
